// [logic/bfpc_pkg.sv]
// package for the battery switch protection configuration block:
// register offsets, field positions, reset values, delay figures and states.
// assumes a 25 MHz system clock shared by the register port and the protection logic.
package bfpc_pkg;

  // register offsets
  localparam logic [7:0] SWITCH_CTRL_ADDR = 8'h04;
  localparam logic [7:0] DISCH_CFG_ADDR = 8'h05;

  // reset values
  localparam logic [7:0] SWITCH_CTRL_RESET = 8'h00;
  localparam logic [7:0] DISCH_CFG_RESET = 8'h00;

  // switch control field positions
  localparam int SLEEP_BIT = 7;
  localparam int LDMON_BIT = 6;
  localparam int RSVD_MSB = 5;
  localparam int RSVD_LSB = 2;
  localparam int CHG_BIT = 1;
  localparam int DSG_BIT = 0;

  // discharge configuration field positions
  localparam int OC_OFF_DIS_BIT = 7;
  localparam int OC_THR_LSB = 5;
  localparam int SHORT_OFF_DIS_BIT = 4;
  localparam int SHORT_THR_LSB = 2;
  localparam int OC_DLY_LSB = 0;

  // delay figures, in their own units
  localparam int CLK_FREQ_HZ = 25000000;
  localparam int OC_DELAY_BASE_US = 160000;
  localparam int OC_DIV_SHIFT = 6;
  localparam int SHORT_DELAY_US = 190;
  localparam int SHORT_LONG_DELAY_US = 10000;

  // derived cycle counts (least times, whole microseconds so exact)
  localparam int CYC_PER_US = CLK_FREQ_HZ / 1000000;
  localparam int OC_BASE_CYCLES = OC_DELAY_BASE_US * CYC_PER_US;
  localparam int SHORT_CYCLES = SHORT_DELAY_US * CYC_PER_US;
  localparam int SHORT_LONG_CYCLES = SHORT_LONG_DELAY_US * CYC_PER_US;

  // power state of the device
  typedef enum logic {BFPC_AWAKE, BFPC_ASLEEP} bfpc_pwr_t;

endpackage : bfpc_pkg

// [logic/bfpc_config.sv]
// switch control and discharge protection configuration registers, with
// the overcurrent and short-circuit delay filters that act on them.
// assumes a serial slave on the same clock presents byte writes and reads
// on the register port; comparator outputs arrive asynchronously.
//
// Contract
// (R1) writing one to sleep bit sleeps: switches, balance outputs, regulator off
// (R2) entering sleep clears charge, discharge and cell-balance switch bits
// (R3) sleep bit self-clears when the device wakes
// (R4) sleep leaves the analog output selection untouched
// (R5) bit 6 turns the load monitor on or off, software only
// (R6) bits 5 to 2 of switch control are reserved, read zero
// (R7) bit 1 drives the charge switch
// (R8) charge overcurrent clears charge bit unless its auto-off is disabled
// (R9) bit 0 drives the discharge switch
// (R10) overcurrent or short clears discharge bit unless that auto-off is disabled
// (R11) config bit 7 one suppresses overcurrent auto turn-off
// (R12) discharge overcurrent always sets its flag and thermistor supply
// (R13) bits 6:5 select overcurrent threshold 0.10 to 0.16 V
// (R14) config bit 4 one suppresses short-circuit auto turn-off
// (R15) short circuit always sets its flag and thermistor supply
// (R16) bits 3:2 select short-circuit threshold 0.20 to 1.20 V
// (R17) bits 1:0 select 160 to 1280 ms, or 2.5 to 20 ms divided
// (R18) registers keep contents in sleep; storage supply moves to bottom cell
// (R19) divider setting one divides the overcurrent delay by 64
// (R20) flags stay set until condition gone and status is read
// (R21) event only after condition persists for the full delay; dropouts restart
`timescale 1ns/1ps
`default_nettype none

module bfpc_config
  import bfpc_pkg::*;
#(
  parameter int OcBaseCycles = OC_BASE_CYCLES,
  parameter int ShortCycles = SHORT_CYCLES,
  parameter int ShortLongCycles = SHORT_LONG_CYCLES
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData,
  input wire logic ocComparator,
  input wire logic shortComparator,
  input wire logic chargeOcEvent,
  input wire logic chargeOcAutoOffDisable,
  input wire logic dischargeDelayDivider,
  input wire logic shortLongDelay,
  input wire logic wakeUp,
  input wire logic statusRead,
  output logic chargeSwitchOn,
  output logic dischargeSwitchOn,
  output logic loadMonitorEnable,
  output logic cellBalanceClear,
  output logic regulatorEnable,
  output logic storageFromCell,
  output logic sleepActive,
  output logic dischargeOcFlag,
  output logic shortCircuitFlag,
  output logic thermistorSupplyOn,
  output logic [1:0] ocThreshold,
  output logic [1:0] shortThreshold,
  output logic [1:0] ocDelaySelect
);

  logic [7:0] dischCfg;
  bfpc_pwr_t pwrState;
  bfpc_pwr_t next_pwrState;
  logic ctrlWrite;
  logic cfgWrite;
  logic sleepReq;
  logic [1:0] compMeta;
  logic [1:0] compSync;
  logic [31:0] dlyCount [2];
  logic [31:0] dlyTarget [2];
  logic [1:0] tripEvent;
  logic ocEvent;
  logic shortEvent;
  logic next_ocFlag;
  logic next_shortFlag;

  assign ctrlWrite = wrEn && (regAddr == SWITCH_CTRL_ADDR);
  assign cfgWrite = wrEn && (regAddr == DISCH_CFG_ADDR);
  assign sleepReq = ctrlWrite && wrData[SLEEP_BIT] && (pwrState == BFPC_AWAKE);
  assign ocEvent = tripEvent[0];
  assign shortEvent = tripEvent[1];

  // threshold and delay codes go straight from the stored fields to the analog side
  assign ocThreshold = dischCfg[OC_THR_LSB+1:OC_THR_LSB]; // R13
  assign shortThreshold = dischCfg[SHORT_THR_LSB+1:SHORT_THR_LSB]; // R16
  assign ocDelaySelect = dischCfg[OC_DLY_LSB+1:OC_DLY_LSB]; // R17

  // discharge configuration: plain storage, kept through sleep
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dischCfg <= DISCH_CFG_RESET;
    end
    else if (cfgWrite)
    begin
      dischCfg <= wrData; // R11 R14 R18
    end
  end

  // sleep state: forced by software, left only by the wake detector
  always_comb
  begin
    next_pwrState = pwrState;
    case (pwrState)
      BFPC_AWAKE:
      begin
        if (sleepReq)
          next_pwrState = BFPC_ASLEEP; // R1
      end
      BFPC_ASLEEP:
      begin
        if (wakeUp)
          next_pwrState = BFPC_AWAKE; // R3
      end
      default:
        next_pwrState = BFPC_AWAKE;
    endcase
  end

  // power outputs follow the state; storage rides on the bottom cell while asleep
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pwrState <= BFPC_AWAKE;
      sleepActive <= 1'b0;
      regulatorEnable <= 1'b1;
      storageFromCell <= 1'b0;
    end
    else
    begin
      pwrState <= next_pwrState;
      sleepActive <= (next_pwrState == BFPC_ASLEEP); // R1 R3
      regulatorEnable <= (next_pwrState == BFPC_AWAKE); // R1
      storageFromCell <= (next_pwrState == BFPC_ASLEEP); // R18
    end
  end

  // one-cycle request to the balance register; analog select is not touched
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cellBalanceClear <= 1'b0;
    end
    else
    begin
      cellBalanceClear <= sleepReq; // R2 R4
    end
  end

  // load monitor: only software changes it, sleep leaves it alone
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      loadMonitorEnable <= SWITCH_CTRL_RESET[LDMON_BIT];
    end
    else if (ctrlWrite)
    begin
      loadMonitorEnable <= wrData[LDMON_BIT]; // R5
    end
  end

  // charge switch: protection clear wins over a software set in the same cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chargeSwitchOn <= SWITCH_CTRL_RESET[CHG_BIT];
    end
    else if (sleepReq || pwrState == BFPC_ASLEEP)
    begin
      chargeSwitchOn <= 1'b0; // R1 R2
    end
    else if (chargeOcEvent && !chargeOcAutoOffDisable)
    begin
      chargeSwitchOn <= 1'b0; // R8
    end
    else if (ctrlWrite)
    begin
      chargeSwitchOn <= wrData[CHG_BIT]; // R7
    end
  end

  // discharge switch: either trip may turn it off, each with its own veto
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dischargeSwitchOn <= SWITCH_CTRL_RESET[DSG_BIT];
    end
    else if (sleepReq || pwrState == BFPC_ASLEEP)
    begin
      dischargeSwitchOn <= 1'b0; // R1 R2
    end
    else if ((ocEvent && !dischCfg[OC_OFF_DIS_BIT])
             || (shortEvent && !dischCfg[SHORT_OFF_DIS_BIT]))
    begin
      dischargeSwitchOn <= 1'b0; // R10 R11 R14
    end
    else if (ctrlWrite)
    begin
      dischargeSwitchOn <= wrData[DSG_BIT]; // R9
    end
  end

  // comparators are analog and asynchronous, so two flops before any use
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      compMeta <= 2'h0;
      compSync <= 2'h0;
    end
    else
    begin
      compMeta <= {shortComparator, ocComparator};
      compSync <= compMeta;
    end
  end

  // delay targets; base shifted by code fits 32 bits for all four codes
  always_comb
  begin
    dlyTarget[0] = 32'(OcBaseCycles) << dischCfg[OC_DLY_LSB+1:OC_DLY_LSB]; // R17
    if (dischargeDelayDivider)
    begin
      dlyTarget[0] = dlyTarget[0] >> OC_DIV_SHIFT; // R19
    end
    dlyTarget[1] = shortLongDelay ? 32'(ShortLongCycles) : 32'(ShortCycles);
  end

  // persistence filters: count while high, restart on any dropout, fire once
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_filter
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          dlyCount[ch] <= 32'h0000_0000;
          tripEvent[ch] <= 1'b0;
        end
        else if (!compSync[ch])
        begin
          dlyCount[ch] <= 32'h0000_0000; // R21
          tripEvent[ch] <= 1'b0;
        end
        else
        begin
          if (dlyCount[ch] < dlyTarget[ch])
          begin
            dlyCount[ch] <= dlyCount[ch] + 32'h0000_0001;
          end
          tripEvent[ch] <= (dlyCount[ch] == dlyTarget[ch] - 32'h0000_0001); // R21
        end
      end
    end
  endgenerate

  // status flags: a new trip beats a clearing read in the same cycle
  always_comb
  begin
    next_ocFlag = dischargeOcFlag;
    next_shortFlag = shortCircuitFlag;
    if (statusRead && !compSync[0])
      next_ocFlag = 1'b0; // R20
    if (statusRead && !compSync[1])
      next_shortFlag = 1'b0; // R20
    if (ocEvent)
      next_ocFlag = 1'b1; // R12
    if (shortEvent)
      next_shortFlag = 1'b1; // R15
  end

  // thermistor supply follows the flags so it drops when software clears them
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dischargeOcFlag <= 1'b0;
      shortCircuitFlag <= 1'b0;
      thermistorSupplyOn <= 1'b0;
    end
    else
    begin
      dischargeOcFlag <= next_ocFlag;
      shortCircuitFlag <= next_shortFlag;
      thermistorSupplyOn <= next_ocFlag || next_shortFlag; // R12 R15
    end
  end

  // read data is registered; unmapped offsets read zero
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdData <= 8'h00;
    end
    else if (rdEn)
    begin
      case (regAddr)
        SWITCH_CTRL_ADDR:
          rdData <= {sleepActive, loadMonitorEnable, 4'h0,
                     chargeSwitchOn, dischargeSwitchOn}; // R6
        DISCH_CFG_ADDR:
          rdData <= dischCfg;
        default:
          rdData <= 8'h00;
      endcase
    end
  end

  // checks
  a_sleep_switches_off: assert property (@(posedge clk) disable iff (!resetn)
    sleepActive |-> !chargeSwitchOn && !dischargeSwitchOn && !regulatorEnable) // R1
    else $error("switch or regulator on while asleep");
  a_sleep_clears_balance: assert property (@(posedge clk) disable iff (!resetn)
    sleepReq |=> cellBalanceClear && sleepActive && storageFromCell) // R2
    else $error("sleep entry did not clear balance or move storage");
  a_wake_clears_sleep: assert property (@(posedge clk) disable iff (!resetn)
    sleepActive && wakeUp |=> !sleepActive && regulatorEnable) // R3
    else $error("sleep bit not cleared on wake");
  a_load_monitor_write: assert property (@(posedge clk) disable iff (!resetn)
    ctrlWrite |=> loadMonitorEnable == $past(wrData[LDMON_BIT])) // R5
    else $error("load monitor enable does not follow write");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
    rdEn && regAddr == SWITCH_CTRL_ADDR |=> rdData[RSVD_MSB:RSVD_LSB] == 4'h0) // R6
    else $error("reserved bits read nonzero");
  a_charge_auto_off: assert property (@(posedge clk) disable iff (!resetn)
    chargeOcEvent && !chargeOcAutoOffDisable |=> !chargeSwitchOn) // R8
    else $error("charge switch not cleared on overcurrent");
  a_discharge_auto_off: assert property (@(posedge clk) disable iff (!resetn)
    (ocEvent && !dischCfg[OC_OFF_DIS_BIT]) || (shortEvent && !dischCfg[SHORT_OFF_DIS_BIT])
    |=> !dischargeSwitchOn) // R10
    else $error("discharge switch not cleared on trip");
  a_trip_sets_flags: assert property (@(posedge clk) disable iff (!resetn)
    ocEvent || shortEvent |=> thermistorSupplyOn
    && (dischargeOcFlag || !$past(ocEvent)) && (shortCircuitFlag || !$past(shortEvent))) // R12
    else $error("trip did not set flag and thermistor supply");
  a_flag_holds: assert property (@(posedge clk) disable iff (!resetn)
    dischargeOcFlag && compSync[0] |=> dischargeOcFlag) // R20
    else $error("overcurrent flag cleared while condition present");
  a_trip_persisted: assert property (@(posedge clk) disable iff (!resetn)
    $rose(ocEvent) |-> $past(compSync[0], 1) && $past(compSync[0], 2)) // R21
    else $error("trip without persistent condition");

endmodule : bfpc_config

`default_nettype wire

// [bench/bfpc_mcu_model.sv]
// microcontroller model: single byte writes and reads on the register port.
// assumes the bench calls xfer; one request at a time, held over the taking edge.
`timescale 1ns/1ps
`default_nettype none
module bfpc_mcu_model
(
  input wire logic clk,
  input wire logic [7:0] rdData,
  output logic wrEn,
  output logic rdEn,
  output logic [7:0] regAddr,
  output logic [7:0] wrData
);
  // idle port at time zero
  initial
  begin
    wrEn = 1'b0;
    rdEn = 1'b0;
    regAddr = 8'hA5;
    wrData = 8'h5A;
  end

  // one byte transfer; the answer is taken just after the taking edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk);
    #1;
    wrEn = wr;
    rdEn = !wr;
    regAddr = a;
    wrData = d;
    @(posedge clk);
    #1;
    wrEn = 1'b0;
    rdEn = 1'b0;
    // released lines are inverted so a stale value never looks valid
    regAddr = ~regAddr;
    wrData = ~wrData;
    q = rdData;
  endtask : xfer
endmodule : bfpc_mcu_model
`default_nettype wire

// [bench/battery_fet_protection_config_test.sv]
// self-checking bench for the switch control and discharge configuration registers.
// assumes short delay parameters so each protection trip takes under twenty cycles.
`timescale 1ns/1ps
`default_nettype none
module battery_fet_protection_config_test
  import bfpc_pkg::*;
;
  logic clk, resetn, wrEn, rdEn, ocComparator, shortComparator, chargeOcEvent;
  logic chargeOcAutoOffDisable, dischargeDelayDivider, shortLongDelay, wakeUp, statusRead;
  logic chargeSwitchOn, dischargeSwitchOn, loadMonitorEnable, cellBalanceClear;
  logic regulatorEnable, storageFromCell, sleepActive, dischargeOcFlag, shortCircuitFlag;
  logic thermistorSupplyOn;
  logic [7:0] regAddr, wrData, rdData;
  logic [1:0] ocThreshold, shortThreshold, ocDelaySelect;
  // reference model state
  logic sl, ld, chg, dsg;
  logic [7:0] cfg;
  logic [31:0] seed;
  int failures, comparisons;

  bfpc_config #(.OcBaseCycles(128), .ShortCycles(8), .ShortLongCycles(16)) uut (.clk(clk),
    .resetn(resetn), .wrEn(wrEn), .rdEn(rdEn), .regAddr(regAddr), .wrData(wrData),
    .rdData(rdData), .ocComparator(ocComparator), .shortComparator(shortComparator),
    .chargeOcEvent(chargeOcEvent), .chargeOcAutoOffDisable(chargeOcAutoOffDisable),
    .dischargeDelayDivider(dischargeDelayDivider), .shortLongDelay(shortLongDelay),
    .wakeUp(wakeUp), .statusRead(statusRead), .chargeSwitchOn(chargeSwitchOn),
    .dischargeSwitchOn(dischargeSwitchOn), .loadMonitorEnable(loadMonitorEnable),
    .cellBalanceClear(cellBalanceClear), .regulatorEnable(regulatorEnable),
    .storageFromCell(storageFromCell), .sleepActive(sleepActive),
    .dischargeOcFlag(dischargeOcFlag), .shortCircuitFlag(shortCircuitFlag),
    .thermistorSupplyOn(thermistorSupplyOn), .ocThreshold(ocThreshold),
    .shortThreshold(shortThreshold), .ocDelaySelect(ocDelaySelect));

  bfpc_mcu_model mcu (.clk(clk), .rdData(rdData), .wrEn(wrEn), .rdEn(rdEn),
    .regAddr(regAddr), .wrData(wrData));

  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic stop_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cycles

  // write through the port and update the model; switch writes are ignored while asleep
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    mcu.xfer(1'b1, a, d, q);
    if (a == DISCH_CFG_ADDR)
      cfg = d;
    else if (a == SWITCH_CTRL_ADDR)
    begin
      // the load monitor stays under software control even while asleep
      ld = d[LDMON_BIT];
      if (!sl)
      begin
        sl = d[SLEEP_BIT];
        chg = d[CHG_BIT] & !d[SLEEP_BIT];
        dsg = d[DSG_BIT] & !d[SLEEP_BIT];
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    mcu.xfer(1'b0, a, 8'h00, q);
    check(q, exp);
  endtask : rd

  function automatic logic [7:0] ctrl_exp();
    return {sl, ld, 4'h0, chg, dsg};
  endfunction : ctrl_exp

  task automatic outs();
    check({2'b00, loadMonitorEnable, chargeSwitchOn, dischargeSwitchOn, sleepActive,
      regulatorEnable, storageFromCell}, {2'b00, ld, chg, dsg, sl, !sl, sl});
  endtask : outs

  // hold a comparator high until its flag rises, then release and clear via status read
  task automatic trip(input logic sp, input int tgt);
    int n;
    n = 0;
    cycles(1);
    if (sp)
      shortComparator = 1'b1;
    else
      ocComparator = 1'b1;
    while ((sp ? shortCircuitFlag : dischargeOcFlag) !== 1'b1 && n < 60)
    begin
      cycles(1);
      n++;
    end
    // two sync flops, the full count, then the flag flop
    check(8'(n), 8'(tgt + 3));
    if (!(sp ? cfg[SHORT_OFF_DIS_BIT] : cfg[OC_OFF_DIS_BIT]))
      dsg = 1'b0;
    outs();
    // a status read while the condition persists must not clear the flag
    statusRead = 1'b1;
    cycles(1);
    statusRead = 1'b0;
    check({6'h00, shortCircuitFlag, dischargeOcFlag}, {6'h00, sp, !sp});
    ocComparator = 1'b0;
    shortComparator = 1'b0;
    cycles(4);
    check({7'h00, thermistorSupplyOn}, 8'h01);
    check({6'h00, shortCircuitFlag, dischargeOcFlag}, {6'h00, sp, !sp});
    statusRead = 1'b1;
    cycles(1);
    statusRead = 1'b0;
    cycles(2);
    check({5'h00, thermistorSupplyOn, shortCircuitFlag, dischargeOcFlag}, 8'h00);
  endtask : trip

  // watchdog, well beyond the expected run length
  initial
  begin
    #(40 * 20000);
    failures++;
    stop_test();
  end

  // main sequence
  initial
  begin
    {resetn, ocComparator, shortComparator, chargeOcEvent, chargeOcAutoOffDisable} = 5'h00;
    {dischargeDelayDivider, shortLongDelay, wakeUp, statusRead} = 4'h0;
    {sl, ld, chg, dsg} = 4'h0;
    cfg = 8'h00;
    seed = 32'hEC3D;
    failures = 0;
    comparisons = 0;
    cycles(20);
    resetn = 1'b1;
    rd(SWITCH_CTRL_ADDR, SWITCH_CTRL_RESET);
    rd(DISCH_CFG_ADDR, DISCH_CFG_RESET);
    rd(8'h07, 8'h00);
    outs();
    $display("test reset done");
    // random fields: config read-back and decode, control bits with reserved ones set
    repeat (8)
    begin
      seed = lfsr_next(seed);
      wr(DISCH_CFG_ADDR, seed[7:0]);
      rd(DISCH_CFG_ADDR, cfg);
      check({2'b00, ocThreshold, shortThreshold, ocDelaySelect},
        {2'b00, cfg[6:5], cfg[3:2], cfg[1:0]});
      wr(SWITCH_CTRL_ADDR, seed[15:8] & 8'h7F);
      rd(SWITCH_CTRL_ADDR, ctrl_exp());
      outs();
    end
    $display("test fields done");
    // charge overcurrent, disabled auto-off first
    wr(SWITCH_CTRL_ADDR, 8'h03);
    for (int dis = 1; dis >= 0; dis--)
    begin
      chargeOcAutoOffDisable = dis[0];
      chargeOcEvent = 1'b1;
      cycles(1);
      chargeOcEvent = 1'b0;
      cycles(2);
      chg = chg & dis[0];
      outs();
    end
    $display("test charge event done");
    // short excursion against the undivided delay must not trip
    wr(DISCH_CFG_ADDR, 8'h00);
    ocComparator = 1'b1;
    cycles(60);
    ocComparator = 1'b0;
    cycles(10);
    check({7'h00, dischargeOcFlag}, 8'h00);
    // every delay code divided, auto-off alternately disabled
    dischargeDelayDivider = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      wr(SWITCH_CTRL_ADDR, 8'h01);
      wr(DISCH_CFG_ADDR, {k[0], 5'h00, k[1:0]});
      trip(1'b0, (128 << k) >> 6);
    end
    // short circuit, both delays, auto-off enabled then disabled
    for (int k = 0; k < 2; k++)
    begin
      shortLongDelay = k[0];
      wr(SWITCH_CTRL_ADDR, 8'h01);
      wr(DISCH_CFG_ADDR, {3'b000, k[0], 4'h0});
      trip(1'b1, k ? 16 : 8);
    end
    $display("test trips done");
    // forced sleep, ignored writes, retention and wake
    wr(DISCH_CFG_ADDR, 8'hB6);
    wr(SWITCH_CTRL_ADDR, 8'h43);
    wr(SWITCH_CTRL_ADDR, 8'h80);
    check({7'h00, cellBalanceClear}, 8'h01);
    outs();
    cycles(1);
    check({7'h00, cellBalanceClear}, 8'h00);
    // switch bits are refused while asleep, the load monitor bit is not
    wr(SWITCH_CTRL_ADDR, 8'h43);
    rd(SWITCH_CTRL_ADDR, ctrl_exp());
    rd(DISCH_CFG_ADDR, cfg);
    wakeUp = 1'b1;
    cycles(1);
    wakeUp = 1'b0;
    cycles(1);
    sl = 1'b0;
    outs();
    rd(SWITCH_CTRL_ADDR, ctrl_exp());
    $display("test sleep done");
    stop_test();
  end
endmodule : battery_fet_protection_config_test
`default_nettype wire
